// file: core/burst_sram_device.sv
`timescale 1ns/1ps
module burst_sram_device
  import sram_pkg::*;
(
  input wire logic clock,     // system clock
  input wire logic rst_n,     // asynchronous reset, active low
  sram_link_if.device link,   // pins toward the controller
  output logic wr_done,       // pulse: a burst was written to the array
  output logic rd_accept      // pulse: a read address was taken
);

  // registered copies of every link input except k_n
  logic in_k;
  logic in_ld;
  logic in_rw;
  logic in_byp;
  logic [ADDR_W-1:0] in_addr;
  logic [WORD_W-1:0] in_dq;
  logic k_prev;

  // edge decode and slot position
  logic k_rise;
  logic kn_rise;
  phase_t ph;
  phase_t next_ph;
  logic slot_a;
  logic slot_b;
  logic half_b;
  logic take_read;
  logic take_write;

  // write burst in flight
  logic w_pend;
  logic [ADDR_W-1:0] w_addr;
  logic [WORD_W-1:0] w_lo;

  // read pipeline, one stage per true-clock rise
  logic p1_v;
  logic [PAIR_W-1:0] p1_pair;
  logic p2_v;
  logic [PAIR_W-1:0] p2_pair;
  logic sel_v;
  logic [PAIR_W-1:0] sel_pair;
  logic [WORD_W-1:0] hi_hold;
  logic launching;

  // 8 M x 18 organised as 4 M two-word bursts
  // array size
  logic [PAIR_W-1:0] mem [0:MEM_DEPTH-1];

  // input registers; every pin except k_n is sampled on a rising system edge
  // input registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_k <= 1'b0;
      in_ld <= 1'b0;
      in_rw <= 1'b0;
      in_byp <= 1'b0;
      in_addr <= ADDR_RESET;
      in_dq <= WORD_RESET;
    end else begin
      in_k <= link.k;
      in_ld <= link.load_strobe;
      in_rw <= link.rw;
      in_byp <= link.pll_bypass_select;
      in_addr <= link.addr;
      in_dq <= link.dq;
    end
  end

  // previous clock level for edge detection
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      k_prev <= 1'b0;
    end else begin
      k_prev <= in_k;
    end
  end

  // a rise of the inverted clock is a fall of the true one
  assign k_rise = in_k & ~k_prev;
  assign kn_rise = ~in_k & k_prev;

  // slot position only moves on the edge the phase expects
  always_comb begin
    next_ph = ph;
    unique case (ph)
      PH_A: begin
        if (kn_rise) begin
          next_ph = PH_AN;
        end
      end
      PH_AN: begin
        if (k_rise) begin
          next_ph = PH_B;
        end
      end
      PH_B: begin
        if (kn_rise) begin
          next_ph = PH_BN;
        end
      end
      PH_BN: begin
        if (k_rise) begin
          next_ph = PH_A;
        end
      end
    endcase
  end

  // reset parks at the last step so the first true rise opens a slot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ph <= PH_BN;
    end else begin
      ph <= next_ph;
    end
  end

  assign slot_a = k_rise & (ph == PH_BN);
  assign slot_b = k_rise & (ph == PH_AN);
  assign half_b = kn_rise & (ph == PH_B);
  assign take_read = slot_a & in_ld & (in_rw == RW_READ);
  assign take_write = slot_a & in_ld & (in_rw != RW_READ);

  // write address held from the address edge to the last word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      w_pend <= 1'b0;
      w_addr <= ADDR_RESET;
    end else if (take_write) begin
      w_pend <= 1'b1;
      w_addr <= in_addr;
    end else if (half_b) begin
      w_pend <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      w_lo <= WORD_RESET;
    end else if (slot_b && w_pend) begin
      w_lo <= in_dq;
    end
  end

  // second word closes the burst; the array write needs no extra strobe
  // self-timed commit
  always_ff @(posedge clock) begin
    if (half_b && w_pend) begin
      mem[w_addr] <= {in_dq, w_lo};
    end
  end

  // completion pulse for the user side
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_done <= 1'b0;
      rd_accept <= 1'b0;
    end else begin
      wr_done <= half_b & w_pend;
      rd_accept <= take_read;
    end
  end

  // a write committed at the previous step is already visible here
  // whole burst fetched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      p1_v <= 1'b0;
      p1_pair <= PAIR_RESET;
      p2_v <= 1'b0;
      p2_pair <= PAIR_RESET;
    end else if (k_rise) begin
      p1_v <= take_read;
      p1_pair <= mem[in_addr];
      p2_v <= p1_v;
      p2_pair <= p1_pair;
    end
  end

  // changing the select with reads in flight may drop or repeat one
  // two-cycle path
  assign sel_v = in_byp ? p2_v : p1_v;
  assign sel_pair = in_byp ? p2_pair : p1_pair;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.dev_dq <= WORD_RESET;
      link.dev_dq_oe <= 1'b0;
      hi_hold <= WORD_RESET;
      launching <= 1'b0;
    end else if (k_rise) begin
      link.dev_dq <= sel_pair[WORD_W-1:0];
      link.dev_dq_oe <= sel_v;
      hi_hold <= sel_pair[PAIR_W-1:WORD_W];
      launching <= sel_v;
    end else if (kn_rise) begin
      link.dev_dq <= hi_hold;
      link.dev_dq_oe <= launching;
      launching <= 1'b0;
    end else begin
      link.dev_dq_oe <= 1'b0;
    end
  end

  // flag follows the enable so it marks exactly the data edges
  // valid flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.read_valid_flag <= 1'b0;
    end else if (k_rise) begin
      link.read_valid_flag <= sel_v;
    end else if (kn_rise) begin
      link.read_valid_flag <= launching;
    end else begin
      link.read_valid_flag <= 1'b0;
    end
  end

  // strobes leave through the same register stage as the data
  // echo strobe pair
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.echo_strobe <= ECHO_RESET;
      link.echo_strobe_n <= ~ECHO_RESET;
    end else begin
      link.echo_strobe <= in_k;
      link.echo_strobe_n <= ~in_k;
    end
  end

endmodule : burst_sram_device

// file: core/burst_sram_host.sv
`timescale 1ns/1ps
module req_fifo
  import sram_pkg::*;
#(
  parameter int WIDTH = REQ_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clock,              // system clock
  input wire logic rst_n,              // asynchronous reset, active low
  input wire logic in_valid,           // write side offers a word
  output logic in_ready,               // room for a word
  input wire logic [WIDTH-1:0] in_data, // word to store
  output logic out_valid,              // a word is waiting
  input wire logic out_ready,          // reader takes the word
  output logic [WIDTH-1:0] out_data    // oldest word
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = store[rd_ptr];

  // storage is plain flops, no reset needed for data
  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // pointers wrap explicitly so depth need not be a power of two
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

endmodule : req_fifo

module burst_sram_host
  import sram_pkg::*;
(
  input wire logic clock,                 // system clock
  input wire logic rst_n,                 // asynchronous reset, active low
  input wire logic pll_bypass_select,     // latency select pin, static
  input wire logic req_valid,             // user offers a request
  output logic req_ready,                 // request buffer has room
  input wire logic req_read,              // 1 read, 0 write
  input wire logic [ADDR_W-1:0] req_addr, // burst address
  input wire logic [PAIR_W-1:0] req_wdata, // write burst, word 0 low
  output logic [PAIR_W-1:0] rd_data,      // read burst, word 0 low
  output logic rd_valid,                  // pulse: rd_data is new
  sram_link_if.host link                  // pins toward the memory
);

  logic byp_meta;
  logic byp_sync;
  phase_t ph;
  phase_t next_ph;
  req_t head;
  req_t in_req;
  logic head_valid;
  logic pop;
  logic last_read;
  logic wr_pend;
  logic [PAIR_W-1:0] wpair;
  logic echo_prev;
  logic echon_prev;
  logic [WORD_W-1:0] lo_cap;

  assign in_req = '{rd: req_read, addr: req_addr, data: req_wdata};

  req_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(in_req),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_data(head)
  );

  // select pin comes from outside, so two flops before use
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      byp_meta <= 1'b0;
      byp_sync <= 1'b0;
      link.pll_bypass_select <= 1'b0;
    end else begin
      byp_meta <= pll_bypass_select;
      byp_sync <= byp_meta;
      link.pll_bypass_select <= byp_sync;
    end
  end

  // link clock is the system clock halved, far below any rated maximum
  // divided clock
  always_comb begin
    unique case (ph)
      PH_A: next_ph = PH_AN;
      PH_AN: next_ph = PH_B;
      PH_B: next_ph = PH_BN;
      PH_BN: next_ph = PH_A;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ph <= PH_A;
    end else begin
      ph <= next_ph;
    end
  end

  assign link.k = ~ph[0];
  assign link.k_n = ph[0];

  // a write right after a two-cycle read would meet the read data
  // hold off contention
  assign pop = head_valid & (ph == PH_BN) & ~(byp_sync & last_read & ~head.rd);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.load_strobe <= 1'b0;
      link.rw <= 1'b0;
      link.addr <= ADDR_RESET;
      last_read <= 1'b0;
    end else if (ph == PH_BN) begin
      link.load_strobe <= pop;
      link.rw <= pop ? head.rd : link.rw;
      link.addr <= pop ? head.addr : link.addr;
      last_read <= pop & head.rd;
    end else begin
      link.load_strobe <= 1'b0;
    end
  end

  // write burst waits for the second half of the slot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wpair <= PAIR_RESET;
    end else if (ph == PH_BN) begin
      wr_pend <= pop & ~head.rd;
      wpair <= head.data;
    end else if (ph == PH_B) begin
      wr_pend <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.host_dq <= WORD_RESET;
      link.host_dq_oe <= 1'b0;
    end else if (ph == PH_AN) begin
      link.host_dq <= wpair[WORD_W-1:0];
      link.host_dq_oe <= wr_pend;
    end else if (ph == PH_B) begin
      link.host_dq <= wpair[PAIR_W-1:WORD_W];
    end else begin
      link.host_dq_oe <= 1'b0;
    end
  end

  // read data taken on echo strobe rises, not on the local phase
  // echo capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      echo_prev <= ECHO_RESET;
      echon_prev <= ~ECHO_RESET;
      lo_cap <= WORD_RESET;
      rd_data <= PAIR_RESET;
      rd_valid <= 1'b0;
    end else begin
      echo_prev <= link.echo_strobe;
      echon_prev <= link.echo_strobe_n;
      rd_valid <= 1'b0;
      if (link.echo_strobe && !echo_prev && link.read_valid_flag) begin
        lo_cap <= link.dq;
      end
      if (link.echo_strobe_n && !echon_prev && link.read_valid_flag) begin
        rd_data <= {link.dq, lo_cap};
        rd_valid <= 1'b1;
      end
    end
  end

endmodule : burst_sram_host

// file: core/sram_link_if.sv
`timescale 1ns/1ps
interface sram_link_if;
  import sram_pkg::*;

  logic k;
  logic k_n;
  logic load_strobe;
  logic rw;
  logic [ADDR_W-1:0] addr;
  logic pll_bypass_select;
  logic [WORD_W-1:0] host_dq;
  logic host_dq_oe;
  logic [WORD_W-1:0] dev_dq;
  logic dev_dq_oe;
  logic echo_strobe;
  logic echo_strobe_n;
  logic read_valid_flag;
  logic [WORD_W-1:0] dq;
  logic contention;

  // shared data pins resolved from the two enables; undriven reads zero
  assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : WORD_RESET);
  assign contention = dev_dq_oe & host_dq_oe;

  modport device (
    input k, k_n, load_strobe, rw, addr, pll_bypass_select, dq,
    output dev_dq, dev_dq_oe, echo_strobe, echo_strobe_n, read_valid_flag
  );

  modport host (
    output k, k_n, load_strobe, rw, addr, pll_bypass_select, host_dq, host_dq_oe,
    input dq, echo_strobe, echo_strobe_n, read_valid_flag
  );

endinterface : sram_link_if

// file: core/sram_pkg.sv
package sram_pkg;

  // array shape: 4 M bursts of two 18-bit words (8 M x 18)
  localparam int ADDR_W = 22;
  localparam int WORD_W = 18;
  localparam int PAIR_W = 2 * WORD_W;
  localparam int MEM_DEPTH = 1 << ADDR_W;

  // read latency in input-clock cycles, chosen by the bypass select pin
  localparam int LAT_SELECT_HIGH = 2;
  localparam int LAT_SELECT_LOW = 1;

  // clock figures in MHz; the link clock is the system clock halved
  localparam int CLOCK_MHZ = 10;
  localparam int K_DIVIDE = 2;
  localparam int K_MAX_MHZ_FAST = 450;
  localparam int K_MAX_MHZ_SLOW = 400;
  localparam int K_MHZ = CLOCK_MHZ / K_DIVIDE;
  localparam bit K_RATE_OK = (K_MHZ <= K_MAX_MHZ_SLOW);

  // request buffer depth in the host
  localparam int FIFO_DEPTH = 4;

  // read/write select encoding
  localparam logic RW_READ = 1'b1;

  // reset values of the pins
  localparam logic ECHO_RESET = 1'b0;
  localparam logic [WORD_W-1:0] WORD_RESET = 18'h00000;
  localparam logic [PAIR_W-1:0] PAIR_RESET = 36'h000000000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 22'h000000;

  // position within a two-clock burst slot; one system cycle per step
  typedef enum logic [1:0] {
    PH_A = 2'b00,  // true clock rise, address edge
    PH_AN = 2'b01, // inverted clock rise
    PH_B = 2'b10,  // true clock rise, write word 0
    PH_BN = 2'b11  // inverted clock rise, write word 1
  } phase_t;

  typedef struct packed {
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [PAIR_W-1:0] data;
  } req_t;

  localparam int REQ_W = $bits(req_t);

endpackage : sram_pkg

// file: test/ddr_burst2_sram_interface_checker.sv
`timescale 1ns/1ps
module ddr_burst2_sram_interface_checker
  import sram_pkg::*;
(
  input wire logic clock,             // system clock
  input wire logic rst_n,             // async reset, active low
  input wire logic k,                 // true link clock
  input wire logic k_n,               // inverted link clock
  input wire logic load_strobe,       // burst start
  input wire logic rw,                // read/write select
  input wire logic pll_bypass_select, // latency select on the link
  input wire logic host_dq_oe,        // host drives the pins
  input wire logic dev_dq_oe,         // device drives the pins
  input wire logic echo_strobe,       // echo strobe, true
  input wire logic echo_strobe_n,     // echo strobe, inverted
  input wire logic read_valid_flag,   // read data on the pins
  input wire logic contention         // both ends drive at once
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // burst starts and the two-word transfers on the pins
  sequence s_read_start;
    load_strobe && rw == RW_READ;
  endsequence
  sequence s_write_start;
    load_strobe && rw != RW_READ;
  endsequence
  sequence s_read_pair;
    (read_valid_flag && dev_dq_oe && k) ##1 (read_valid_flag && dev_dq_oe && !k)
      ##1 !read_valid_flag;
  endsequence
  sequence s_write_pair;
    (host_dq_oe && k) ##1 (host_dq_oe && !k) ##1 !host_dq_oe;
  endsequence

  property p_one_addr_per_slot;
    load_strobe |=> !load_strobe [*3];
  endproperty
  property p_addr_true_edge;
    load_strobe |-> k;
  endproperty
  property p_write_pair;
    s_write_start |-> ##2 s_write_pair;
  endproperty
  property p_read_lat_low;
    s_read_start and !pll_bypass_select |-> ##4 s_read_pair;
  endproperty
  property p_read_lat_high;
    s_read_start and pll_bypass_select |-> ##6 s_read_pair;
  endproperty
  property p_flag_marks_data;
    read_valid_flag == dev_dq_oe;
  endproperty
  property p_no_contention;
    !contention;
  endproperty
  property p_echo_aligned;
    read_valid_flag |-> (k ? $rose(echo_strobe) : $rose(echo_strobe_n));
  endproperty
  property p_launch_true;
    $rose(dev_dq_oe) |-> k;
  endproperty
  // the second write word rides the inverted clock, so it must mirror the true one
  property p_clock_pair;
    k_n == !k;
  endproperty

  a_one_addr_per_slot: assert property (p_one_addr_per_slot)
    else $error("second address inside one burst slot");
  a_addr_true_edge: assert property (p_addr_true_edge)
    else $error("address presented off the true clock rise");
  a_write_pair: assert property (p_write_pair)
    else $error("write words not on true then inverted rise");
  a_read_lat_low: assert property (p_read_lat_low)
    else $error("read data not one cycle after address");
  a_read_lat_high: assert property (p_read_lat_high)
    else $error("read data not two cycles after address");
  a_flag_marks_data: assert property (p_flag_marks_data)
    else $error("valid flag differs from device drive");
  a_no_contention: assert property (p_no_contention)
    else $error("both ends drive the data pins");
  a_echo_aligned: assert property (p_echo_aligned)
    else $error("echo strobe edge not aligned with read word");
  a_launch_true: assert property (p_launch_true)
    else $error("read burst launched off the true rise");
  a_clock_pair: assert property (p_clock_pair)
    else $error("inverted link clock not complementary");
endmodule : ddr_burst2_sram_interface_checker

// file: test/tb_ddr_burst2_sram_interface.sv
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module tb_ddr_burst2_sram_interface
  import sram_pkg::*;
;
  logic clock, rst_n, bypass, req_valid, req_ready, req_read, rd_valid, wr_done, rd_accept;
  logic [ADDR_W-1:0] req_addr;
  logic [PAIR_W-1:0] req_wdata, rd_data;
  logic [PAIR_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [PAIR_W-1:0] wr_q[$], rdw_q[$], rd_q[$];
  logic [ADDR_W-1:0] wa[$];
  logic [31:0] seed = 32'h2313;
  int error_cnt = 0, n_compared = 0, n_wr = 0, n_rd = 0, n_wdone = 0, n_racc = 0;
  bit saw_full = 0;
  int n_ld = 0;
  real k_seen = -1.0;

  sram_link_if link_if();
  burst_sram_device burst_sram_device_inst (.clock(clock), .rst_n(rst_n), .link(link_if),
    .wr_done(wr_done), .rd_accept(rd_accept));
  burst_sram_host burst_sram_host_inst (.clock(clock), .rst_n(rst_n),
    .pll_bypass_select(bypass), .req_valid(req_valid), .req_ready(req_ready),
    .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata), .rd_data(rd_data),
    .rd_valid(rd_valid), .link(link_if));
  ddr_burst2_sram_interface_checker ddr_burst2_sram_interface_checker_inst (.clock(clock),
    .rst_n(rst_n), .k(link_if.k), .k_n(link_if.k_n),
    .load_strobe(link_if.load_strobe), .rw(link_if.rw),
    .pll_bypass_select(link_if.pll_bypass_select), .host_dq_oe(link_if.host_dq_oe),
    .dev_dq_oe(link_if.dev_dq_oe), .echo_strobe(link_if.echo_strobe),
    .echo_strobe_n(link_if.echo_strobe_n), .read_valid_flag(link_if.read_valid_flag),
    .contention(link_if.contention));

  // 10 MHz system clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // offer one request; valid is set high again and left up, so back-to-back pushes leave no gap
  task automatic push(input logic rd, input logic [ADDR_W-1:0] a, input logic [PAIR_W-1:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_read <= rd;
    req_addr <= a;
    req_wdata <= d;
    @(negedge clock);
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (n >= 200) begin
      error_cnt++;
      $display("request never taken");
    end
    @(posedge clock);
    if (rd) begin
      rdw_q.push_back(mem[a]);
      rd_q.push_back(mem[a]);
      n_rd++;
    end else begin
      mem[a] = d;
      wr_q.push_back(d);
      wa.push_back(a);
      n_wr++;
    end
  endtask : push

  // wire and user-side monitor; values seen are those before the edge
  always @(posedge clock) begin
    if (rst_n === 1'b1) begin
      if (link_if.host_dq_oe === 1'b1) begin
        if (link_if.k === 1'b1)
          `CHECK("write word0", wr_q[0][WORD_W-1:0], link_if.dq)
        else begin
          `CHECK("write word1", wr_q[0][PAIR_W-1:WORD_W], link_if.dq)
          void'(wr_q.pop_front());
        end
      end
      if (link_if.read_valid_flag === 1'b1) begin
        if (link_if.k === 1'b1)
          `CHECK("read word0", rdw_q[0][WORD_W-1:0], link_if.dq)
        else begin
          `CHECK("read word1", rdw_q[0][PAIR_W-1:WORD_W], link_if.dq)
          void'(rdw_q.pop_front());
        end
      end
      if (rd_valid === 1'b1) begin
        `CHECK("rd_data", rd_q[0], rd_data)
        void'(rd_q.pop_front());
      end
      if (wr_done === 1'b1)
        n_wdone++;
      if (rd_accept === 1'b1)
        n_racc++;
      if (link_if.load_strobe === 1'b1)
        n_ld++;
      if (req_valid === 1'b1 && req_ready === 1'b0)
        saw_full = 1;
    end
  end

  // link clock period measured between true rises once out of reset
  // measured link rate
  always @(posedge link_if.k) begin
    if (rst_n === 1'b1) begin
      if (k_seen >= 0.0)
        `CHECK("link clock MHz", K_MHZ, int'(1000.0 / ($realtime - k_seen)))
      k_seen = $realtime;
    end
  end

  // main sequence: both latency modes, boundary addresses, then a random mix
  initial begin
    int n;
    rst_n = 1'b0;
    bypass = 1'b0;
    req_valid = 1'b0;
    req_read = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      // select changes only while idle; in-flight reads could be lost
      bypass <= m[0];
      repeat (12) @(posedge clock);
      push(1'b0, '0, 36'h0aaaa5555);
      push(1'b0, '1, 36'hfffffffff);
      push(1'b1, '0, '0);
      push(1'b0, '0, 36'h123456789);
      push(1'b1, '0, '0);
      push(1'b1, '1, '0);
      for (int i = 0; i < 16; i++) begin
        if (rnd() % 2 == 0)
          push(1'b0, ADDR_W'(rnd()), PAIR_W'({rnd(), rnd()}));
        else
          push(1'b1, wa[rnd() % wa.size()], '0);
      end
      req_valid <= 1'b0;
      n = 0;
      while ((rd_q.size() + wr_q.size() + rdw_q.size()) != 0 && n < 300) begin
        @(posedge clock);
        n++;
      end
      repeat (8) @(posedge clock);
    end
    `CHECK("writes done", n_wr, n_wdone)
    `CHECK("reads taken", n_rd, n_racc)
    `CHECK("buffer refused", 1'b1, saw_full)
    `CHECK("queues drained", 0, rd_q.size() + wr_q.size() + rdw_q.size())
    // nop slots leave the strobe low, so strobes equal requests
    `CHECK("bursts started", n_wr + n_rd, n_ld)
    end_of_test();
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule : tb_ddr_burst2_sram_interface
